// File: design/dccp_pkg.sv
// constants, types and decoders for the dual capture/compare/pwm block
// Functional notes
// - each unit has a 16-bit value register for capture, compare or pwm duty.
// - the value register is reached as separate low and high byte registers.
// - both units behave alike except for the special event trigger action.
// - first unit special event trigger clears the shared 16-bit timebase.
// - second unit trigger clears the timebase and starts conversion when converter enabled.
// - two capturing units sample the same shared 16-bit timebase count.
// - pwm units share the period timer, so duty updates land together.
// - each unit has its own control register; bits 7 and 6 read zero.
// - mode field zero disables the unit and resets its internal state.
// - each capture sets the unit event flag until software clears it.
package dccp_pkg;

	// ****************************************
	// register indices (byte address = index * 4)
	// ****************************************
	localparam logic [7:0] IDX_UNIT1_CONTROL = 8'h17;
	localparam logic [7:0] IDX_UNIT2_CONTROL = 8'h1D;
	localparam logic [7:0] IDX_UNIT1_LOW     = 8'h20;
	localparam logic [7:0] IDX_UNIT1_HIGH    = 8'h21;
	localparam logic [7:0] IDX_UNIT2_LOW     = 8'h22;
	localparam logic [7:0] IDX_UNIT2_HIGH    = 8'h23;
	localparam logic [7:0] IDX_STATUS        = 8'h24;
	localparam logic [7:0] IDX_MASK          = 8'h25;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int         CTRL_DUTY_HI_POS = 5;
	localparam int         CTRL_DUTY_LO_POS = 4;
	localparam logic [7:0] CTRL_WMASK       = 8'h3F;
	localparam logic [7:0] CTRL_RESET       = 8'h00;
	localparam logic [15:0] VALUE_RESET     = 16'h0000;
	localparam logic [1:0] STATUS_RESET     = 2'h0;
	localparam logic [1:0] MASK_RESET       = 2'h0;
	localparam logic [3:0] PRESC_RESET      = 4'h0;
	localparam logic [3:0] PRESC_LAST_4     = 4'h3;
	localparam logic [3:0] PRESC_LAST_16    = 4'hF;

	// ****************************************
	// mode field encodings
	// ****************************************
	localparam logic [3:0] MODE_OFF         = 4'h0;
	localparam logic [3:0] MODE_CAP_FALL    = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE    = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4   = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16  = 4'h7;
	localparam logic [3:0] MODE_CMP_SET     = 4'h8;
	localparam logic [3:0] MODE_CMP_CLEAR   = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT    = 4'hA;
	localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;

	typedef enum logic [1:0] {
		DCCP_OFF,
		DCCP_CAPTURE,
		DCCP_COMPARE,
		DCCP_PWM
	} dccp_mode_type;

	typedef struct packed {
		logic [15:0] t1_count;
		logic [7:0]  t2_count;
		logic        t2_period_evt;
	} dccp_timebase_type;

	typedef struct packed {
		logic t1_clear;
		logic adc_start;
	} dccp_trig_type;

	// codes 0001..0011 are unused and act as off
	function automatic dccp_mode_type decode_mode(input logic [3:0] m);
		if (m[3:2] == 2'h3)
			return DCCP_PWM;
		else if (m[3:2] == 2'h2)
			return DCCP_COMPARE;
		else if (m[3:2] == 2'h1)
			return DCCP_CAPTURE;
		else
			return DCCP_OFF;
	endfunction

	function automatic logic is_mapped(input logic [7:0] idx);
		return idx == IDX_UNIT1_CONTROL || idx == IDX_UNIT2_CONTROL || idx == IDX_UNIT1_LOW ||
			idx == IDX_UNIT1_HIGH || idx == IDX_UNIT2_LOW || idx == IDX_UNIT2_HIGH ||
			idx == IDX_STATUS || idx == IDX_MASK;
	endfunction

endpackage

// File: design/dccp_top.sv
// dual capture/compare/pwm units with apb register slave
`timescale 1ns/1ns
module dccp_top (
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [9:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire dccp_pkg::dccp_timebase_type timebase,
	input  wire logic [1:0]                  cap_pin,
	input  wire logic                        adc_enable,
	output dccp_pkg::dccp_trig_type          trig,
	output logic      [1:0]                  cmp_pin,
	output logic      [1:0]                  pwm_pin,
	output logic                             irq
);

	// ****************************************
	// apb decode
	// ****************************************
	logic [7:0]  idx;
	logic        setup;
	logic        wr_en;
	logic        rd_done;
	logic [7:0]  ctrl [2];
	logic [15:0] value [2];
	logic [9:0]  duty_latch [2];
	logic [1:0]  status;
	logic [1:0]  mask;
	logic [1:0]  rd_snap;
	logic [1:0]  cap_evt;
	logic [1:0]  cmp_evt;
	logic [1:0]  special;
	logic [1:0]  pwm_on;
	logic [3:0]  presc [2];
	logic        mapped;

	assign idx     = paddr[9:2];
	assign mapped  = dccp_pkg::is_mapped(idx) && paddr[1:0] == 2'h0;
	assign setup   = psel && !penable;
	// zero wait states: every access phase completes at once
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_en   = psel && penable && pwrite && mapped;
	assign rd_done = psel && penable && !pwrite && idx == dccp_pkg::IDX_STATUS && mapped;

	// read data and status snapshot are caught in the setup cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prdata  <= 32'h0000_0000;
			rd_snap <= dccp_pkg::STATUS_RESET;
		end else if (setup) begin
			rd_snap <= status;
			prdata  <= 32'h0000_0000;
			if (!pwrite && paddr[1:0] == 2'h0) begin
				unique case (idx)
					dccp_pkg::IDX_UNIT1_CONTROL: prdata[7:0] <= ctrl[0] & dccp_pkg::CTRL_WMASK;
					dccp_pkg::IDX_UNIT2_CONTROL: prdata[7:0] <= ctrl[1] & dccp_pkg::CTRL_WMASK;
					dccp_pkg::IDX_UNIT1_LOW:     prdata[7:0] <= value[0][7:0];
					dccp_pkg::IDX_UNIT1_HIGH:    prdata[7:0] <= value[0][15:8];
					dccp_pkg::IDX_UNIT2_LOW:     prdata[7:0] <= value[1][7:0];
					dccp_pkg::IDX_UNIT2_HIGH:    prdata[7:0] <= value[1][15:8];
					dccp_pkg::IDX_STATUS:        prdata[1:0] <= status;
					dccp_pkg::IDX_MASK:          prdata[1:0] <= mask;
					default:                     prdata      <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************
	// per-unit logic
	// ****************************************
	// one identical body for both units; only the trigger differs
	genvar u;
	generate
		for (u = 0; u < 2; u++) begin : g_unit
			localparam logic [7:0] IDX_CTRL = (u == 0) ? dccp_pkg::IDX_UNIT1_CONTROL : dccp_pkg::IDX_UNIT2_CONTROL;
			localparam logic [7:0] IDX_LOW  = (u == 0) ? dccp_pkg::IDX_UNIT1_LOW : dccp_pkg::IDX_UNIT2_LOW;
			localparam logic [7:0] IDX_HIGH = (u == 0) ? dccp_pkg::IDX_UNIT1_HIGH : dccp_pkg::IDX_UNIT2_HIGH;

			dccp_pkg::dccp_mode_type mode;
			logic                    pin_prev;
			logic                    rise;
			logic                    fall;
			logic                    match;
			logic                    match_prev;
			logic                    presc_last;

			assign mode   = dccp_pkg::decode_mode(ctrl[u][3:0]);
			assign pwm_on[u] = mode == dccp_pkg::DCCP_PWM;
			assign rise   = cap_pin[u] && !pin_prev;
			assign fall   = !cap_pin[u] && pin_prev;
			assign presc_last = (ctrl[u][3:0] == dccp_pkg::MODE_CAP_RISE4) ?
				presc[u][1:0] == dccp_pkg::PRESC_LAST_4[1:0] : presc[u] == dccp_pkg::PRESC_LAST_16;

			always_comb begin
				unique case (ctrl[u][3:0])
					dccp_pkg::MODE_CAP_FALL:   cap_evt[u] = fall;
					dccp_pkg::MODE_CAP_RISE:   cap_evt[u] = rise;
					dccp_pkg::MODE_CAP_RISE4,
					dccp_pkg::MODE_CAP_RISE16: cap_evt[u] = rise && presc_last;
					default:                   cap_evt[u] = 1'b0;
				endcase
			end

			// compare works against the 16-bit timebase
			assign match = mode == dccp_pkg::DCCP_COMPARE && timebase.t1_count == value[u];
			// one event per match, not one per cycle that the count sits there
			assign cmp_evt[u] = match && !match_prev;
			assign special[u] = cmp_evt[u] && ctrl[u][3:0] == dccp_pkg::MODE_CMP_SPECIAL;

			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					pin_prev   <= 1'b0;
					match_prev <= 1'b0;
				end else begin
					pin_prev   <= cap_pin[u];
					match_prev <= match;
				end
			end

			// prescaler cleared whenever not capturing, incl. mode zero
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst)
					presc[u] <= dccp_pkg::PRESC_RESET;
				else if (mode != dccp_pkg::DCCP_CAPTURE)
					presc[u] <= dccp_pkg::PRESC_RESET;
				else if (rise)
					presc[u] <= presc[u] + 4'h1;
			end

			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst)
					ctrl[u] <= dccp_pkg::CTRL_RESET;
				else if (wr_en && idx == IDX_CTRL)
					ctrl[u] <= pwdata[7:0] & dccp_pkg::CTRL_WMASK;
			end

			// hardware loads win over a software byte write in the same cycle
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					value[u] <= dccp_pkg::VALUE_RESET;
				end else if (cap_evt[u]) begin
					value[u] <= timebase.t1_count;
				end else if (pwm_on[u] && timebase.t2_period_evt) begin
					// high byte shows the duty in force after the period event
					value[u][15:8] <= value[u][7:0];
				end else if (wr_en) begin
					// separate byte access; high byte read-only under pwm
					if (idx == IDX_LOW)
						value[u][7:0] <= pwdata[7:0];
					if (idx == IDX_HIGH && !pwm_on[u])
						value[u][15:8] <= pwdata[7:0];
				end
			end

			// duty taken at the shared period event
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst)
					duty_latch[u] <= 10'h000;
				else if (!pwm_on[u])
					duty_latch[u] <= 10'h000;
				else if (timebase.t2_period_evt)
					duty_latch[u] <= {value[u][7:0], ctrl[u][dccp_pkg::CTRL_DUTY_HI_POS],
						ctrl[u][dccp_pkg::CTRL_DUTY_LO_POS]};
			end

			// pwm runs from the period timer count
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst)
					pwm_pin[u] <= 1'b0;
				else
					pwm_pin[u] <= pwm_on[u] && {timebase.t2_count, 2'h0} < duty_latch[u];
			end

			// outputs drop when the unit is off
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst)
					cmp_pin[u] <= 1'b0;
				else if (mode != dccp_pkg::DCCP_COMPARE)
					cmp_pin[u] <= 1'b0;
				else if (cmp_evt[u] && ctrl[u][3:0] == dccp_pkg::MODE_CMP_SET)
					cmp_pin[u] <= 1'b1;
				else if (cmp_evt[u] && ctrl[u][3:0] == dccp_pkg::MODE_CMP_CLEAR)
					cmp_pin[u] <= 1'b0;
			end
		end
	endgenerate

	// ****************************************
	// special event trigger
	// ****************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			trig <= '0;
		end else begin
			trig.t1_clear  <= |special;
			// second unit also starts a conversion if enabled
			trig.adc_start <= special[1] && adc_enable;
		end
	end

	// ****************************************
	// interrupt status and mask
	// ****************************************
	// sticky flag; only bits seen by the read are cleared, a new event wins
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			status <= dccp_pkg::STATUS_RESET;
		else
			status <= (status & ~(rd_done ? rd_snap : 2'h0)) | cap_evt | cmp_evt;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			mask <= dccp_pkg::MASK_RESET;
		else if (wr_en && idx == dccp_pkg::IDX_MASK)
			mask <= pwdata[1:0];
	end

	assign irq = |(status & mask);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_setup_read(logic [7:0] i);
		psel && !penable && !pwrite && paddr == {i, 2'h0};
	endsequence

	sequence s_access;
		psel && penable;
	endsequence

	chk_capture_loads_value: assert property (
		cap_evt[0] |=> value[0] == $past(timebase.t1_count))
		else $error("capture did not load the timebase count");

	chk_shared_timebase: assert property (
		cap_evt[0] && cap_evt[1] |=> value[0] == value[1])
		else $error("simultaneous captures differ");

	chk_byte_write_low: assert property (
		wr_en && idx == dccp_pkg::IDX_UNIT2_LOW && !cap_evt[1] && !(pwm_on[1] && timebase.t2_period_evt) |=>
			value[1][7:0] == $past(pwdata[7:0]))
		else $error("low byte write lost");

	chk_flag_on_capture: assert property (
		cap_evt[1] && !(setup && !pwrite && idx == dccp_pkg::IDX_STATUS) |=> status[1] [*2])
		else $error("capture flag not held");

	chk_t1_clear_trigger: assert property (
		special[0] |=> trig.t1_clear ##1 !$past(special[0]) || trig.t1_clear)
		else $error("timebase clear missing");

	chk_adc_start_gate: assert property (
		##1 trig.adc_start == $past(special[1] && adc_enable))
		else $error("conversion start wrong");

	chk_ctrl_top_zero: assert property (
		s_setup_read(dccp_pkg::IDX_UNIT1_CONTROL) ##1 s_access |-> prdata[7:6] == 2'h0)
		else $error("control top bits not zero");

	chk_disable_resets: assert property (
		ctrl[0][3:0] == dccp_pkg::MODE_OFF [*2] |-> presc[0] == 4'h0 && !cmp_pin[0] && !pwm_pin[0])
		else $error("disabled unit kept state");

	chk_pwm_shared_update: assert property (
		timebase.t2_period_evt && pwm_on == 2'h3 |=>
			duty_latch[0][9:2] == value[0][15:8] && duty_latch[1][9:2] == value[1][15:8])
		else $error("pwm duty not updated together");

	chk_irq_level: assert property (
		$rose(status[0]) && mask[0] |-> ##0 irq)
		else $error("interrupt not raised");

	chk_capture_unit2: assert property (
		cap_evt[1] |=> value[1] == $past(timebase.t1_count))
		else $error("second unit capture did not load the timebase count");

	chk_byte_write_high: assert property (
		wr_en && idx == dccp_pkg::IDX_UNIT1_HIGH && !cap_evt[0] && !pwm_on[0] |=>
			value[0][15:8] == $past(pwdata[7:0]))
		else $error("high byte write lost");

	chk_high_byte_hold: assert property (
		pwm_on[0] && !timebase.t2_period_evt |=> $stable(value[0][15:8]))
		else $error("pwm high byte changed between period events");

	chk_duty_hold: assert property (
		pwm_on[1] && !timebase.t2_period_evt |=> $stable(duty_latch[1]))
		else $error("pwm duty changed between period events");

	chk_cmp_pin_set: assert property (
		cmp_evt[0] && ctrl[0][3:0] == dccp_pkg::MODE_CMP_SET |=> cmp_pin[0])
		else $error("compare match did not set the pin");

	chk_cmp_pin_clear: assert property (
		cmp_evt[0] && ctrl[0][3:0] == dccp_pkg::MODE_CMP_CLEAR |=> !cmp_pin[0])
		else $error("compare match did not clear the pin");

	chk_special_pin_hold: assert property (
		cmp_evt[1] && ctrl[1][3:0] == dccp_pkg::MODE_CMP_SPECIAL |=> $stable(cmp_pin[1]))
		else $error("special event moved the compare pin");

	chk_compare_flag: assert property (
		cmp_evt[1] |=> status[1])
		else $error("compare match did not set the flag");

	chk_unit2_off: assert property (
		(ctrl[1][3:0] == dccp_pkg::MODE_OFF) [*2] |-> presc[1] == 4'h0 && !cmp_pin[1] && !pwm_pin[1])
		else $error("disabled second unit kept state");

	chk_pwm_off_low: assert property (
		!pwm_on[1] |=> !pwm_pin[1])
		else $error("pwm pin high outside pwm mode");

	chk_unit2_clear: assert property (
		special[1] |=> trig.t1_clear)
		else $error("second unit trigger did not clear the timebase");

	chk_unit1_no_adc: assert property (
		special[0] && !special[1] |=> !trig.adc_start)
		else $error("first unit trigger started a conversion");

	chk_status_read_clear: assert property (
		rd_done && rd_snap[0] && !cap_evt[0] && !cmp_evt[0] |=> !status[0])
		else $error("status read did not clear the flag");

	chk_flag_sticky: assert property (
		status[0] && !rd_done |=> status[0])
		else $error("flag dropped without a status read");

	chk_ctrl2_top_zero: assert property (
		s_setup_read(dccp_pkg::IDX_UNIT2_CONTROL) ##1 s_access |-> prdata[7:6] == 2'h0)
		else $error("second control top bits not zero");

endmodule

// File: testbench/dccp_timer_model.sv
// timer side model feeding the shared timebase
`timescale 1ns/1ns
module dccp_timer_model #(
	parameter logic [7:0] T2_PERIOD = 8'h0F
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	input  wire dccp_pkg::dccp_trig_type trig,
	output dccp_pkg::dccp_timebase_type  timebase
);
	logic [15:0] t1;
	logic [7:0]  t2;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			t1 <= '0;
		else if (trig.t1_clear)
			t1 <= '0;
		else
			t1 <= t1 + 16'h0001;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			t2 <= '0;
		else if (t2 == T2_PERIOD)
			t2 <= '0;
		else
			t2 <= t2 + 8'h01;
	end
	assign timebase = {t1, t2, t2 == T2_PERIOD};
endmodule

// File: testbench/tb_top.sv
// self-checking bench for the dual capture/compare/pwm block
`timescale 1ns/1ns
module tb_top;
	logic                        sys_clk = 0;
	logic                        rst = 1;
	logic                        psel = 0;
	logic                        penable = 0;
	logic                        pwrite = 0;
	logic [9:0]                  paddr = '0;
	logic [31:0]                 pwdata = '0;
	logic [31:0]                 prdata;
	logic                        pready;
	logic                        pslverr;
	dccp_pkg::dccp_timebase_type timebase;
	logic [1:0]                  cap_pin = '0;
	logic                        adc_enable = 0;
	dccp_pkg::dccp_trig_type     trig;
	logic [1:0]                  cmp_pin;
	logic [1:0]                  pwm_pin;
	logic                        irq;
	int                          error_cnt = 0;
	int                          n_compared = 0;
	int                          cycles = 0;
	int                          n_clr = 0;
	int                          n_adc = 0;
	logic [7:0]                  d;
	logic                        e;

	dccp_top dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.timebase, .cap_pin, .adc_enable, .trig, .cmp_pin, .pwm_pin, .irq);
	dccp_timer_model #(.T2_PERIOD(8'h0F)) model (.sys_clk, .rst, .trig, .timebase);

	always #10 sys_clk = ~sys_clk;
	// trigger pulses counted so scenarios compare before and after
	always @(posedge sys_clk) begin
		cycles++;
		n_clr += trig.t1_clear;
		n_adc += trig.adc_start;
		if (cycles == 30000) begin
			error_cnt++;
			stop_test();
		end
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic stop_test;
		if (error_cnt == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
		n_compared++;
		if (g !== x) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd);
		@(posedge sys_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {a, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		d = prdata[7:0];
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rc(input string n, input logic [7:0] a, input logic [7:0] x);
		xfer(0, a, 8'h00);
		chk(n, 16'(x), 16'(d));
	endtask
	task automatic wait_irq;
		int i = 0;
		do begin
			tick(1);
			i++;
		end while (irq !== 1'b1 && i < 400);
		chk("irq", 16'h1, 16'(irq));
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		logic [7:0] ix[8] = '{8'h17, 8'h1D, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25};
		foreach (ix[i]) rc("reset_value", ix[i], 8'h00);
		xfer(0, 8'h30, 8'h00);
		chk("unmapped_err", 16'h1, 16'(e));
		chk("unmapped_data", 16'h0, 16'(d));
		xfer(1, 8'h17, 8'hFF);
		rc("ctrl1_top", 8'h17, 8'h3F);
		xfer(1, 8'h1D, 8'hFF);
		rc("ctrl2_top", 8'h1D, 8'h3F);
		xfer(1, 8'h17, 8'h00);
		xfer(1, 8'h1D, 8'h00);
		for (int i = 2; i < 6; i++)
			xfer(1, ix[i], ix[i] ^ 8'hA5);
		for (int i = 2; i < 6; i++)
			rc("value_byte", ix[i], ix[i] ^ 8'hA5);
	endtask
	task automatic t_cmp;
		logic [3:0]  m;
		logic [15:0] v;
		int          c;
		int          a;
		for (int i = 0; i < 4; i++) begin
			m = dccp_pkg::MODE_CMP_SET + i[3:0];
			v = timebase.t1_count + 16'h0080;
			c = n_clr;
			a = n_adc;
			xfer(1, 8'h20, v[7:0]);
			xfer(1, 8'h21, v[15:8]);
			xfer(1, 8'h17, {4'h0, m});
			wait_irq();
			tick(2);
			chk("cmp_pin", 16'(m == 4'h8), 16'(cmp_pin[0]));
			chk("unit1_clear", 16'(m == 4'hB), 16'(n_clr != c));
			chk("unit1_adc", 16'h0, 16'(n_adc != a));
			xfer(1, 8'h17, 8'h00);
			tick(2);
			chk("off_pin", 16'h0, 16'(cmp_pin[0]));
			xfer(0, 8'h24, 8'h00);
		end
	endtask
	task automatic t_adc;
		logic [15:0] v;
		int          c;
		int          a;
		for (int en = 0; en < 2; en++) begin
			@(posedge sys_clk);
			adc_enable <= en[0];
			v = timebase.t1_count + 16'h0080;
			c = n_clr;
			a = n_adc;
			xfer(1, 8'h22, v[7:0]);
			xfer(1, 8'h23, v[15:8]);
			// comparing unit set to the clearing trigger
			xfer(1, 8'h1D, 8'h0B);
			wait_irq();
			tick(2);
			chk("unit2_clear", 16'h1, 16'(n_clr != c));
			chk("unit2_adc", 16'(en), 16'(n_adc != a));
			xfer(1, 8'h1D, 8'h00);
			xfer(0, 8'h24, 8'h00);
		end
	endtask
	task automatic t_cap_pair;
		logic [15:0] t0;
		logic [15:0] v1;
		logic [15:0] v2;
		xfer(1, 8'h17, 8'h05);
		xfer(1, 8'h1D, 8'h05);
		@(posedge sys_clk);
		t0 = timebase.t1_count;
		cap_pin <= 2'h3;
		tick(4);
		chk("cap_irq", 16'h1, 16'(irq));
		xfer(0, 8'h20, 8'h00);
		v1[7:0] = d;
		xfer(0, 8'h21, 8'h00);
		v1[15:8] = d;
		xfer(0, 8'h22, 8'h00);
		v2[7:0] = d;
		xfer(0, 8'h23, 8'h00);
		v2[15:8] = d;
		chk("cap_same", v1, v2);
		chk("cap_window", 16'h1, 16'(v1 - t0 < 16'h0008));
		rc("cap_status", 8'h24, 8'h03);
		rc("status_clear", 8'h24, 8'h00);
		chk("irq_low", 16'h0, 16'(irq));
		@(posedge sys_clk);
		cap_pin <= 2'h0;
		xfer(1, 8'h17, 8'h00);
		xfer(1, 8'h1D, 8'h00);
	endtask
	task automatic pulse;
		@(posedge sys_clk);
		cap_pin[1] <= 1'b1;
		repeat (3) @(posedge sys_clk);
		cap_pin[1] <= 1'b0;
		tick(3);
	endtask
	task automatic t_cap_pre;
		int n[4] = '{1, 1, 4, 16};
		for (int i = 0; i < 4; i++) begin
			xfer(1, 8'h1D, 8'h00);
			xfer(1, 8'h1D, 8'h04 + 8'(i));
			xfer(0, 8'h24, 8'h00);
			repeat (n[i] - 1) pulse();
			rc("pre_early", 8'h24, 8'h00);
			pulse();
			rc("pre_event", 8'h24, 8'h02);
		end
		xfer(1, 8'h1D, 8'h00);
	endtask
	task automatic t_pwm;
		int h1 = 0;
		int h2 = 0;
		xfer(1, 8'h20, 8'h02);
		xfer(1, 8'h17, 8'h0C);
		xfer(1, 8'h22, 8'h03);
		xfer(1, 8'h1D, 8'h3C);
		tick(40);
		repeat (16) begin
			h1 += pwm_pin[0];
			h2 += pwm_pin[1];
			tick(1);
		end
		chk("pwm1_high", 16'h2, h1[15:0]);
		chk("pwm2_high", 16'h4, h2[15:0]);
		xfer(1, 8'h17, 8'h00);
		xfer(1, 8'h1D, 8'h00);
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 0;
		t_regs();
		xfer(1, 8'h25, 8'h03);
		// converter left enabled so first unit triggers must still start nothing
		t_adc();
		t_cmp();
		t_cap_pair();
		t_cap_pre();
		t_pwm();
		stop_test();
	end
endmodule
